// [isr_flag_bank.sv]
// clear-on-read interrupt flag bank
`timescale 1ns/1ps
`default_nettype none
module isr_flag_bank
(
  input  wire logic core_clk,
  input  wire logic nrst,
  isr_flag_if.bank  fl
);

  // ----------------------------------------------------------------
  // one sticky flag per implemented bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      if (isr_pkg::FLG_USED[gi])
      begin : g_used
        logic flag_r;
        logic flag_nxt;
        // a set in the clearing cycle wins so no event is lost
        assign flag_nxt = fl.set_vec[gi] | (flag_r & ~fl.clr);
        always_ff @(posedge core_clk)
        begin
          if (!nrst)
            flag_r <= isr_pkg::RST_INT_FLAGS[gi];
          else
            flag_r <= flag_nxt;
        end
        assign fl.flags[gi] = flag_r;
      end
      else
      begin : g_unused
        assign fl.flags[gi] = 1'b0;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [isr_flag_if.sv]
// interface between the register front end and the flag bank
`timescale 1ns/1ps
`default_nettype none
interface isr_flag_if;
  logic [7:0] set_vec;
  logic       clr;
  logic [7:0] flags;
  modport bank (input set_vec, input clr, output flags);
  modport user (output set_vec, output clr, input flags);
endinterface
`default_nettype wire

// [isr_host.sv]
// host model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module isr_host
(
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // idle bus from time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one access: strobe for one cycle, address and data held across the taking edge;
  // afterwards the lines show the inverse so stale values never look valid
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [isr_pkg.sv]
// constants and types shared by the status and result register bank
`default_nettype none
package isr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INT_FLAGS  = 8'h1d;
  localparam logic [7:0] OFF_STEP_LOW   = 8'h1e;
  localparam logic [7:0] OFF_STEP_HIGH  = 8'h1f;
  localparam logic [7:0] OFF_GEST_ACT   = 8'h20;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h70;
  localparam logic [7:0] OFF_EVT_MASK   = 8'h71;

  // ----------------------------------------------------------------
  // interrupt flag layout
  // ----------------------------------------------------------------
  localparam int unsigned FLG_FIFO_FULL = 0;
  localparam int unsigned FLG_FIFO_WM   = 1;
  localparam int unsigned FLG_ERROR     = 2;
  localparam int unsigned FLG_AUX_DRDY  = 5;
  localparam int unsigned FLG_GYR_DRDY  = 6;
  localparam int unsigned FLG_ACC_DRDY  = 7;
  localparam logic [7:0]  FLG_USED      = 8'he7;

  // ----------------------------------------------------------------
  // result field layout and event status layout
  // ----------------------------------------------------------------
  localparam int unsigned GEST_LSB = 0;
  localparam int unsigned ACT_LSB  = 3;
  localparam int unsigned EVT_STEP = 0;
  localparam int unsigned EVT_GEST = 1;
  localparam int unsigned EVT_ACT  = 2;
  localparam logic [2:0]  EVT_USED = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_INT_FLAGS = 8'h00;
  localparam logic [15:0] RST_STEP      = 16'h0000;
  localparam logic [2:0]  RST_EVT       = 3'h0;

  typedef enum logic [2:0] {
    GEST_UNKNOWN   = 3'b000,
    GEST_PUSH_DOWN = 3'b001,
    GEST_PIVOT_UP  = 3'b010,
    GEST_SHAKE     = 3'b011,
    GEST_FLICK_IN  = 3'b100,
    GEST_FLICK_OUT = 3'b101
  } isr_gest_e;

  typedef enum logic [1:0] {
    ACT_STILL   = 2'b00,
    ACT_WALKING = 2'b01,
    ACT_RUNNING = 2'b10,
    ACT_UNKNOWN = 2'b11
  } isr_act_e;

endpackage
`default_nettype wire

// [isr_regs.sv]
// status and result register bank of the motion sensor
`timescale 1ns/1ps
`default_nettype none
module isr_regs
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // event pulses from the sensor core
  input  wire logic        ev_fifo_full,
  input  wire logic        ev_fifo_wm,
  input  wire logic        ev_error,
  input  wire logic        ev_aux_drdy,
  input  wire logic        ev_gyr_drdy,
  input  wire logic        ev_acc_drdy,
  // results from the feature engine
  input  wire logic        init_done,
  input  wire logic [15:0] step_cnt,
  input  wire logic        step_vld,
  input  wire logic [2:0]  gest_code,
  input  wire logic        gest_vld,
  input  wire logic [1:0]  act_code,
  input  wire logic        act_vld,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  wire logic hit_flags = addr_is(reg_addr, isr_pkg::OFF_INT_FLAGS);
  wire logic hit_slow  = addr_is(reg_addr, isr_pkg::OFF_STEP_LOW);
  wire logic hit_shigh = addr_is(reg_addr, isr_pkg::OFF_STEP_HIGH);
  wire logic hit_res   = addr_is(reg_addr, isr_pkg::OFF_GEST_ACT);
  wire logic hit_est   = addr_is(reg_addr, isr_pkg::OFF_EVT_STATUS);
  wire logic hit_emsk  = addr_is(reg_addr, isr_pkg::OFF_EVT_MASK);

  // only the event status and mask take writes; the rest ignore them
  wire logic wr_est  = reg_wr & hit_est;
  wire logic wr_emsk = reg_wr & hit_emsk;

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  isr_flag_if fl ();

  // bits 3 and 4 have no source and stay low
  assign fl.set_vec = {ev_acc_drdy,
                       ev_gyr_drdy,
                       ev_aux_drdy,
                       2'b00,
                       ev_error,
                       ev_fifo_wm,
                       ev_fifo_full};
  // the whole register clears as its read data leaves on the bus
  assign fl.clr = reg_rd & hit_flags;

  isr_flag_bank u_flags
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .fl       (fl)
  );

  // ----------------------------------------------------------------
  // step count
  // ----------------------------------------------------------------
  logic [15:0] step_r;
  logic [15:0] step_nxt;

  assign step_nxt = step_vld ? step_cnt : step_r;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      step_r <= isr_pkg::RST_STEP;
    else
      step_r <= step_nxt;
  end

  // ----------------------------------------------------------------
  // gesture and activity result
  // ----------------------------------------------------------------
  isr_pkg::isr_gest_e gest_r;
  isr_pkg::isr_gest_e gest_nxt;
  isr_pkg::isr_act_e  act_r;
  isr_pkg::isr_act_e  act_nxt;
  isr_pkg::isr_gest_e gest_in;

  // codes 6 and 7 are undefined; they fold to unknown rather than leak
  always_comb
  begin
    case (gest_code)
      3'h1:    gest_in = isr_pkg::GEST_PUSH_DOWN;
      3'h2:    gest_in = isr_pkg::GEST_PIVOT_UP;
      3'h3:    gest_in = isr_pkg::GEST_SHAKE;
      3'h4:    gest_in = isr_pkg::GEST_FLICK_IN;
      3'h5:    gest_in = isr_pkg::GEST_FLICK_OUT;
      default: gest_in = isr_pkg::GEST_UNKNOWN;
    endcase
  end

  assign gest_nxt = gest_vld ? gest_in : gest_r;

  // a fresh classification beats the init load in the same cycle
  assign act_nxt = act_vld   ? isr_pkg::isr_act_e'(act_code) :
                   init_done ? isr_pkg::ACT_UNKNOWN : act_r;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      gest_r <= isr_pkg::GEST_UNKNOWN;
      act_r  <= isr_pkg::ACT_STILL;
    end
    else
    begin
      gest_r <= gest_nxt;
      act_r  <= act_nxt;
    end
  end

  wire logic [7:0] res_val = {3'b000, act_r, gest_r};

  // ----------------------------------------------------------------
  // event status and mask
  // ----------------------------------------------------------------
  logic [2:0] est_r;
  logic [2:0] est_nxt;
  logic [2:0] emsk_r;
  logic [2:0] emsk_nxt;
  logic       irq_r;

  wire logic [2:0] est_set = {act_vld | init_done, gest_vld, step_vld};

  // write-one-to-clear, but a same-cycle event keeps its bit
  assign est_nxt = est_set | (est_r & ~(wr_est ? reg_wdata[2:0] : 3'h0));

  // the level follows the next mask, so it never lags a mask write by a cycle
  assign emsk_nxt = wr_emsk ? (reg_wdata[2:0] & isr_pkg::EVT_USED) : emsk_r;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      est_r  <= isr_pkg::RST_EVT;
      emsk_r <= isr_pkg::RST_EVT;
      irq_r  <= 1'b0;
    end
    else
    begin
      est_r  <= est_nxt;
      emsk_r <= emsk_nxt;
      irq_r  <= |(est_nxt & emsk_nxt);
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_r;

  // unmapped addresses read zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_flags)
      rd_mux = fl.flags;
    else if (hit_slow)
      rd_mux = step_r[7:0];
    else if (hit_shigh)
      rd_mux = step_r[15:8];
    else if (hit_res)
      rd_mux = res_val;
    else if (hit_est)
      rd_mux = {5'h00, est_r};
    else if (hit_emsk)
      rd_mux = {5'h00, emsk_r};
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else
      rdata_r <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_flag_read;
    reg_rd && hit_flags;
  endsequence

  sequence s_quiet_events;
    fl.set_vec == 8'h00;
  endsequence

  // flag bank: set, hold, clear on read
  a_flag_read_clear: assert property (
    s_flag_read ##0 s_quiet_events |=> fl.flags == 8'h00)
    else $error("flags not cleared by read");

  a_flag_read_data: assert property (
    s_flag_read |=> reg_rdata == $past(fl.flags))
    else $error("flag read data wrong");

  a_flag_set_wins: assert property (
    ev_fifo_full && fl.clr |=> fl.flags[isr_pkg::FLG_FIFO_FULL])
    else $error("fifo full event lost in clear");

  a_wm_flag_set: assert property (
    ev_fifo_wm |=> fl.flags[isr_pkg::FLG_FIFO_WM])
    else $error("watermark flag not set");

  a_err_flag_set: assert property (
    ev_error |=> fl.flags[isr_pkg::FLG_ERROR])
    else $error("error flag not set");

  // without a read or an event the flags must not move
  a_flags_sticky: assert property (
    !fl.clr && fl.set_vec == 8'h00 |=> fl.flags == $past(fl.flags))
    else $error("flags changed with no cause");

  a_aux_drdy_set: assert property (
    ev_aux_drdy |=> fl.flags[isr_pkg::FLG_AUX_DRDY])
    else $error("aux ready flag not set");

  a_gyr_drdy_set: assert property (
    ev_gyr_drdy |=> fl.flags[isr_pkg::FLG_GYR_DRDY])
    else $error("gyro ready flag not set");

  a_acc_drdy_hold: assert property (
    ev_acc_drdy ##1 !fl.clr[*2] |=> fl.flags[isr_pkg::FLG_ACC_DRDY])
    else $error("accel ready flag not held");

  a_spare_flags_zero: assert property (
    fl.flags[4:3] == 2'b00)
    else $error("spare flag bits set");

  // step count
  sequence s_step_update;
    step_vld ##1 !step_vld[*2];
  endsequence

  a_step_load: assert property (
    step_vld |=> step_r == $past(step_cnt))
    else $error("step count not loaded");

  a_step_bytes: assert property (
    s_step_update ##0 (reg_rd && hit_shigh)
      |=> reg_rdata == $past(step_cnt[15:8], 3))
    else $error("step high byte wrong");

  a_step_low: assert property (
    reg_rd && hit_slow |=> reg_rdata == $past(step_r[7:0]))
    else $error("step low byte wrong");

  a_step_high: assert property (
    reg_rd && hit_shigh |=> reg_rdata == $past(step_r[15:8]))
    else $error("step high byte not live");

  // result register, reserved flag bits, ignored writes and idle read data
  a_gesture_field: assert property (
    gest_vld && gest_code <= 3'h5 |=> gest_r == $past(gest_code))
    else $error("gesture field wrong");

  a_gest_fold: assert property (
    gest_vld && gest_code > 3'h5 |=> gest_r == isr_pkg::GEST_UNKNOWN)
    else $error("undefined gesture not folded");

  a_activity_field: assert property (
    act_vld |=> act_r == $past(act_code))
    else $error("activity field wrong");

  a_act_over_init: assert property (
    act_vld && init_done |=> act_r == $past(act_code))
    else $error("init load beat a fresh activity");

  a_init_unknown: assert property (
    init_done && !act_vld |=> act_r == isr_pkg::ACT_UNKNOWN)
    else $error("activity not unknown after init");

  a_result_read: assert property (
    reg_rd && hit_res |=> reg_rdata == {3'b000, $past(act_r), $past(gest_r)})
    else $error("result read data wrong");

  a_reserved_zero: assert property (
    reg_rd && hit_flags |=> reg_rdata[4:3] == 2'b00)
    else $error("reserved flag bits not zero");

  a_result_top_zero: assert property (
    reg_rd && hit_res |=> reg_rdata[7:5] == 3'b000)
    else $error("result top bits not zero");

  a_write_ignored: assert property (
    reg_wr && hit_slow && !step_vld |=> step_r == $past(step_r))
    else $error("write altered step count");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

  // event status, mask and interrupt
  a_evt_clear: assert property (
    wr_est && est_set == 3'h0 |=> est_r == ($past(est_r) & ~$past(reg_wdata[2:0])))
    else $error("event status not cleared by write");

  a_mask_write: assert property (
    wr_emsk |=> emsk_r == $past(reg_wdata[2:0]))
    else $error("mask write lost");

  a_irq_level: assert property (
    irq == |(est_r & emsk_r))
    else $error("irq level disagrees with events");

endmodule
`default_nettype wire

// [isr_tb.sv]
// self-checking bench for the status and result register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [5:0]  ev;
  logic [3:0]  vld;
  logic [15:0] step_cnt;
  logic [2:0]  gest_code;
  logic [1:0]  act_code;
  logic        irq;
  logic        rd_d;
  logic [31:0] xs_state;
  logic [31:0] r;
  logic [7:0]  exp_q[$];
  int          fails;
  int          tests_run;
  int          cyc;
  int unsigned pos[6];

  // ----------------------------------------------------------------
  // clock, partner and device
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  isr_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_wr(reg_wr), .reg_rd(reg_rd));

  isr_regs DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_fifo_full(ev[0]), .ev_fifo_wm(ev[1]), .ev_error(ev[2]), .ev_aux_drdy(ev[3]),
    .ev_gyr_drdy(ev[4]), .ev_acc_drdy(ev[5]), .init_done(vld[3]), .step_cnt(step_cnt),
    .step_vld(vld[0]), .gest_code(gest_code), .gest_vld(vld[1]), .act_code(act_code),
    .act_vld(vld[2]), .irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    xs_state = xs_state ^ (xs_state << 13);
    xs_state = xs_state ^ (xs_state >> 17);
    xs_state = xs_state ^ (xs_state << 5);
    return xs_state;
  endfunction

  // read with the expected answer noted first, so notes stay in bus order
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask

  // one-cycle pulse on event and valid inputs with the data that go with them
  task automatic pulse(input logic [5:0] e, input logic [3:0] v, input logic [15:0] s,
                       input logic [2:0] g, input logic [1:0] a);
    @(posedge core_clk);
    ev        <= e;
    vld       <= v;
    step_cnt  <= s;
    gest_code <= g;
    act_code  <= a;
    @(posedge core_clk);
    ev        <= 6'h00;
    vld       <= 4'h0;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq", {7'h00, irq}, {7'h00, e});
  endtask

  // ----------------------------------------------------------------
  // watchers
  // ----------------------------------------------------------------
  // read data stand only in the cycle after the strobe, so sample exactly there
  always @(posedge core_clk)
  begin
    if (rd_d && exp_q.size() > 0)
      check("rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end

  // hang guard, far above the fewer than two hundred cycles the sequence needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0; ev = 6'h00; vld = 4'h0; step_cnt = 16'h0000;
    gest_code = 3'h0; act_code = 2'h0; rd_d = 1'b0; xs_state = 32'h00000052;
    fails = 0; tests_run = 0; cyc = 0;
    pos = '{isr_pkg::FLG_FIFO_FULL, isr_pkg::FLG_FIFO_WM, isr_pkg::FLG_ERROR,
            isr_pkg::FLG_AUX_DRDY, isr_pkg::FLG_GYR_DRDY, isr_pkg::FLG_ACC_DRDY};
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, then an unmapped hole
    rd(8'h1d, 8'h00);
    rd(8'h1e, 8'h00);
    rd(8'h1f, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h55, 8'h00);
    irq_is(1'b0);
    // each flag alone, then cleared by the read that reported it
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'h01 << i, 4'h0, 16'h0000, 3'h0, 2'h0);
      rd(8'h1d, 8'h01 << pos[i]);
      rd(8'h1d, 8'h00);
    end
    // all flags; bits 3 and 4 stay zero and a write changes nothing
    pulse(6'h3f, 4'h0, 16'h0000, 3'h0, 2'h0);
    host.access(8'h1d, 8'h00, 1'b1);
    rd(8'h1d, 8'he7);
    rd(8'h1d, 8'h00);
    // an event landing with the clearing read survives it
    fork
      rd(8'h1d, 8'h00);
      pulse(6'h21, 4'h0, 16'h0000, 3'h0, 2'h0);
    join
    rd(8'h1d, 8'h81);
    // random step counts, byte order, writes ignored
    for (int i = 0; i < 3; i++)
    begin
      r = xs();
      pulse(6'h00, 4'h1, r[15:0], 3'h0, 2'h0);
      rd(8'h1f, r[15:8]);
      host.access(8'h1e, ~r[7:0], 1'b1);
      rd(8'h1e, r[7:0]);
    end
    // every gesture code, out-of-range codes read as unknown
    for (int g = 0; g < 8; g++)
    begin
      pulse(6'h00, 4'h2, 16'h0000, g[2:0], 2'h0);
      rd(8'h20, (g <= 5) ? g[7:0] : 8'h00);
    end
    // every activity code in bits 4:3
    for (int a = 0; a < 4; a++)
    begin
      pulse(6'h00, 4'h4, 16'h0000, 3'h0, a[1:0]);
      rd(8'h20, {3'h0, a[1:0], 3'h0});
    end
    // initialization loads unknown; a result in the same cycle takes precedence
    pulse(6'h00, 4'h8, 16'h0000, 3'h0, 2'h0);
    host.access(8'h20, 8'hff, 1'b1);
    rd(8'h20, 8'h18);
    pulse(6'h00, 4'hc, 16'h0000, 3'h0, 2'h1);
    rd(8'h20, 8'h08);
    // interrupt: masked, unmasked, cleared, raised again
    irq_is(1'b0);
    host.access(8'h71, 8'h01, 1'b1);
    irq_is(1'b1);
    host.access(8'h70, 8'h01, 1'b1);
    irq_is(1'b0);
    rd(8'h70, 8'h06);
    rd(8'h71, 8'h01);
    pulse(6'h00, 4'h1, 16'h1234, 3'h0, 2'h0);
    irq_is(1'b1);
    host.access(8'h71, 8'h00, 1'b1);
    irq_is(1'b0);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
